// *** src/fq_queue.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fq_consts.svh"
module fq_queue
(
    // Clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // AHB-Lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    // Clears
    input  wire logic             aclr,
    input  wire logic             sclr,
    // Write side
    input  wire fq_pkg::fq_wr_s   wr_in,
    output var fq_pkg::fq_stat_s  wr_stat,
    // Read side
    input  wire logic             rd_req,
    output var fq_pkg::fq_data_t  rd_data,
    output var fq_pkg::fq_stat_s  rd_stat
);
    import fq_pkg::*;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic                  ap_ok;
    logic                  wph_q;
    logic                  wph_d;
    logic [`FQ_AW_BUS-1:0] addr_q;
    logic [`FQ_AW_BUS-1:0] addr_d;
    logic [31:0]           rdat_bus_q;
    logic [31:0]           rdat_bus_d;
    fq_ctrl_s              ctrl_q;
    fq_ctrl_s              ctrl_d;
    logic                  soft_clr_q;
    logic                  soft_clr_d;
    logic                  ovf_err_q;
    logic                  ovf_err_d;
    logic                  udf_err_q;
    logic                  udf_err_d;
    logic                  full_q;
    logic                  empty_q;
    logic                  rfull_q;
    logic                  wempty_q;
    fq_cnt_t               cnt_q;

    // Zero wait state; odd sizes are ignored
    assign ap_ok = hsel & hready & htrans[`FQ_HTRANS_BIT]
                 & (hsize == `FQ_HSIZE_WORD);
    assign hreadyout = 1'b1;
    assign hresp     = `FQ_RESP_OKAY;
    assign hrdata    = rdat_bus_q;

    always_comb
    begin
        wph_d      = ap_ok & hwrite;
        addr_d     = ap_ok ? haddr[`FQ_AW_BUS-1:0] : addr_q;
        ctrl_d     = ctrl_q;
        soft_clr_d = 1'b0;
        ovf_err_d  = ovf_err_q;
        udf_err_d  = udf_err_q;
        if (wph_q && addr_q == `FQ_OFF_CTRL)
        begin
            ctrl_d     = hwdata[`FQ_C_SYNC:`FQ_C_OVF];
            soft_clr_d = hwdata[`FQ_C_SCLR];
        end
        if (wph_q && addr_q == `FQ_OFF_STAT)
        begin
            if (hwdata[`FQ_S_OVF_ERR])
                ovf_err_d = 1'b0;
            if (hwdata[`FQ_S_UDF_ERR])
                udf_err_d = 1'b0;
        end
        // Set beats a simultaneous clear
        if (wr_in.req && full_q)
            ovf_err_d = 1'b1;
        if (rd_req && empty_q)
            udf_err_d = 1'b1;
        // Read data caught at the address phase, ctrl forwarded
        rdat_bus_d = rdat_bus_q;
        if (ap_ok && !hwrite)
        begin
            rdat_bus_d = '0;
            case (haddr[`FQ_AW_BUS-1:0])
                `FQ_OFF_CTRL:
                    rdat_bus_d[`FQ_C_SYNC:`FQ_C_OVF] = ctrl_d;
                `FQ_OFF_STAT:
                begin
                    rdat_bus_d[`FQ_S_FULL]    = full_q;
                    rdat_bus_d[`FQ_S_EMPTY]   = empty_q;
                    rdat_bus_d[`FQ_S_RFULL]   = rfull_q;
                    rdat_bus_d[`FQ_S_WEMPTY]  = wempty_q;
                    rdat_bus_d[`FQ_S_OVF_ERR] = ovf_err_q;
                    rdat_bus_d[`FQ_S_UDF_ERR] = udf_err_q;
                    rdat_bus_d[`FQ_S_LVL_HI:`FQ_S_LVL_LO] = cnt_q;
                end
                default:
                    rdat_bus_d = '0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wph_q      <= 1'b0;
            addr_q     <= '0;
            rdat_bus_q <= '0;
            ctrl_q     <= `FQ_CTRL_RST;
            soft_clr_q <= 1'b0;
            ovf_err_q  <= 1'b0;
            udf_err_q  <= 1'b0;
        end
        else
        begin
            wph_q      <= wph_d;
            addr_q     <= addr_d;
            rdat_bus_q <= rdat_bus_d;
            ctrl_q     <= ctrl_d;
            soft_clr_q <= soft_clr_d;
            ovf_err_q  <= ovf_err_d;
            udf_err_q  <= udf_err_d;
        end
    end

    // ------------------------------------------------------------
    // Clear release
    // ------------------------------------------------------------
    logic arst_n;
    logic rel1_q;
    logic rel2_q;
    logic core_rst_n;

    assign arst_n = hresetn & ~aclr;

    // Assertion is immediate, release waits two edges
    always_ff @(posedge hclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rel1_q <= 1'b0;
            rel2_q <= 1'b0;
        end
        else
        begin
            rel1_q <= 1'b1;
            rel2_q <= rel1_q;
        end
    end

    // Change the sync bit only while aclr is high: the mux can glitch
    assign core_rst_n = ctrl_q.sync ? rel2_q : arst_n;

    // ------------------------------------------------------------
    // Queue core
    // ------------------------------------------------------------
    fq_data_t mem [`FQ_DEPTH];
    fq_ptr_t  wptr_q;
    fq_ptr_t  wptr_d;
    fq_ptr_t  rptr_q;
    fq_ptr_t  rptr_d;
    fq_cnt_t  cnt_d;
    fq_data_t rdat_q;
    fq_data_t rdat_d;
    fq_data_t head_word;
    logic     full_d;
    logic     empty_d;
    logic     push;
    logic     pop;
    logic     clr;
    logic     mem_we;

    assign head_word = mem[rptr_q];

    // Pointers wrap at the depth by their own width
    function automatic fq_ptr_t ptr_inc(input fq_ptr_t p);
        return p + `FQ_PTR_ONE;
    endfunction

    always_comb
    begin
        clr    = sclr | soft_clr_q;
        push   = wr_in.req & ~(ctrl_q.ovf & full_q);
        pop    = rd_req & ~(ctrl_q.udf & empty_q);
        mem_we = push & ~clr;
        wptr_d = push ? ptr_inc(wptr_q) : wptr_q;
        rptr_d = pop ? ptr_inc(rptr_q) : rptr_q;
        cnt_d  = cnt_q;
        if (push && !pop)
            cnt_d = cnt_q + `FQ_CNT_ONE;
        else if (pop && !push)
            cnt_d = cnt_q - `FQ_CNT_ONE;
        rdat_d = rdat_q;
        if (ctrl_q.show)
        begin
            if (cnt_d != `FQ_CNT_ZERO && !clr)
                rdat_d = (push && rptr_d == wptr_q) ? wr_in.data : mem[rptr_d];
        end
        else if (pop)
            rdat_d = head_word;
        if (clr)
        begin
            wptr_d = `FQ_PTR_ZERO;
            rptr_d = `FQ_PTR_ZERO;
            cnt_d  = `FQ_CNT_ZERO;
        end
        full_d  = (cnt_d == `FQ_CNT_FULL);
        empty_d = (cnt_d == `FQ_CNT_ZERO);
    end

    // One clock times both sides
    always_ff @(posedge hclk or negedge core_rst_n)
    begin
        if (!core_rst_n)
        begin
            wptr_q   <= `FQ_PTR_ZERO;
            rptr_q   <= `FQ_PTR_ZERO;
            cnt_q    <= `FQ_CNT_ZERO;
            rdat_q   <= '0;
            full_q   <= 1'b0;
            empty_q  <= 1'b1;
            rfull_q  <= 1'b0;
            wempty_q <= 1'b1;
        end
        else
        begin
            wptr_q   <= wptr_d;
            rptr_q   <= rptr_d;
            cnt_q    <= cnt_d;
            rdat_q   <= rdat_d;
            full_q   <= full_d;
            empty_q  <= empty_d;
            rfull_q  <= full_q;
            wempty_q <= empty_q;
        end
    end

    // Storage needs no reset
    always_ff @(posedge hclk)
    begin
        if (mem_we)
            mem[wptr_q] <= wr_in.data;
    end

    // Each side sees its own flags; opposite flag lags a cycle
    assign wr_stat = '{full: full_q, empty: wempty_q, level: cnt_q};
    assign rd_stat = '{full: rfull_q, empty: empty_q, level: cnt_q};
    assign rd_data = rdat_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_guard_full_blk: assert property (
        @(posedge hclk) disable iff (!core_rst_n)
        ctrl_q.ovf && full_q && wr_in.req && !rd_req && !clr
        |=> $stable(wptr_q) && cnt_q == `FQ_CNT_FULL)
        else $error("write taken while full with guard on");

    a_guard_empty_blk: assert property (
        @(posedge hclk) disable iff (!core_rst_n)
        ctrl_q.udf && empty_q && rd_req && !clr
        |=> $stable(rptr_q))
        else $error("read advanced while empty with guard on");

    a_push_stores: assert property (
        @(posedge hclk) disable iff (!core_rst_n)
        mem_we |=> mem[$past(wptr_q)] == $past(wr_in.data))
        else $error("pushed word not stored");

    a_normal_read_lat: assert property (
        @(posedge hclk) disable iff (!core_rst_n)
        !ctrl_q.show && pop && !clr |=> rd_data == $past(head_word))
        else $error("normal mode data not one cycle after request");

    a_show_head_out: assert property (
        @(posedge hclk) disable iff (!core_rst_n)
        ctrl_q.show && $stable(ctrl_q.show) && !empty_q
        |-> rd_data == head_word)
        else $error("show-ahead output is not the oldest word");

    a_sclr_empties: assert property (
        @(posedge hclk) disable iff (!core_rst_n)
        sclr |=> empty_q && !full_q && cnt_q == `FQ_CNT_ZERO)
        else $error("sync clear did not empty queue");

    a_aclr_status: assert property (
        @(posedge hclk) disable iff (!hresetn)
        aclr |-> wr_stat.level == `FQ_CNT_ZERO && rd_stat.empty && !wr_stat.full)
        else $error("async clear did not reset status");

    a_rdfull_lag: assert property (
        @(posedge hclk) disable iff (!core_rst_n)
        ##1 rd_stat.full == $past(wr_stat.full))
        else $error("read-side full not one cycle behind");

    a_sync_release: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $fell(aclr) && ctrl_q.sync && $stable(ctrl_q.sync)
        |-> !core_rst_n ##1 !core_rst_n ##1 core_rst_n)
        else $error("synchronised clear release not two edges");

    c_fill_full: cover property (
        @(posedge hclk) disable iff (!core_rst_n)
        full_q && wr_in.req);

    c_show_pop: cover property (
        @(posedge hclk) disable iff (!core_rst_n)
        ctrl_q.show && pop ##1 pop);

    c_sync_clear: cover property (
        @(posedge hclk) disable iff (!hresetn)
        ctrl_q.sync && $fell(aclr));

    c_push_pop: cover property (
        @(posedge hclk) disable iff (!core_rst_n)
        push && pop && !empty_q);
endmodule
`default_nettype wire

// *** src/fq_consts.svh ***
// Functional notes
// - Single build clocks everything on one edge
// - Write and read side flags kept apart
// - Rising edges time data, requests and flags
// - Word stored on edge with write request
// - Write data width equals configured width
// - Overflow guard blocks writes when full
// - Optional clear release synchronised to clock
// - Read request follows normal or show-ahead mode
// - Underflow guard blocks reads when empty
// - Async clear resets status at once
// - Read width equals write width here
`ifndef FQ_CONSTS_SVH
`define FQ_CONSTS_SVH

`define FQ_WIDTH        8
`define FQ_DEPTH        16
`define FQ_AW           4
`define FQ_CW           5
`define FQ_CNT_FULL     5'h10
`define FQ_CNT_ONE      5'h01
`define FQ_CNT_ZERO     5'h00
`define FQ_PTR_ONE      4'h1
`define FQ_PTR_ZERO     4'h0

`define FQ_OFF_CTRL     8'h00
`define FQ_OFF_STAT     8'h04
`define FQ_CTRL_RST     4'h3
`define FQ_C_OVF        0
`define FQ_C_SYNC       3
`define FQ_C_SCLR       4
`define FQ_S_FULL       0
`define FQ_S_EMPTY      1
`define FQ_S_RFULL      2
`define FQ_S_WEMPTY     3
`define FQ_S_OVF_ERR    4
`define FQ_S_UDF_ERR    5
`define FQ_S_LVL_LO     8
`define FQ_S_LVL_HI     12

`define FQ_HTRANS_BIT   1
`define FQ_HSIZE_WORD   3'h2
`define FQ_RESP_OKAY    1'b0
`define FQ_AW_BUS       8

`endif

// *** src/fq_pkg.sv ***
`include "fq_consts.svh"
package fq_pkg;
    typedef logic [`FQ_WIDTH-1:0] fq_data_t;
    typedef logic [`FQ_AW-1:0]    fq_ptr_t;
    typedef logic [`FQ_CW-1:0]    fq_cnt_t;

    typedef struct packed {
        logic     req;
        fq_data_t data;
    } fq_wr_s;

    typedef struct packed {
        logic    full;
        logic    empty;
        fq_cnt_t level;
    } fq_stat_s;

    typedef struct packed {
        logic sync;
        logic show;
        logic udf;
        logic ovf;
    } fq_ctrl_s;
endpackage

// *** dv/fq_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module fq_far_end
(
    // Bench commands
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic             rude,
    input  wire fq_pkg::fq_data_t pdata,
    // Queue status
    input  wire fq_pkg::fq_stat_s wr_stat,
    input  wire fq_pkg::fq_stat_s rd_stat,
    // Requests
    output var fq_pkg::fq_wr_s    wr_in,
    output logic                  rd_req
);
    import fq_pkg::*;
    // ----------------------------------------
    // Flag-gated writer and reader
    // ----------------------------------------
    // Rude mode ignores the flags, only for the guard tests
    always_comb
    begin
        wr_in.req  = push & (rude | ~wr_stat.full);
        wr_in.data = wr_in.req ? pdata : ~pdata;
        rd_req     = pop & (rude | ~rd_stat.empty);
    end
endmodule
`default_nettype wire

// *** dv/test_fifo_port_interface.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fq_consts.svh"
module test_fifo_port_interface;
    import fq_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, aclr, sclr, push, pop, rude;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, rd_req;
    fq_data_t    pdata, rd_data;
    fq_wr_s      wr_in;
    fq_stat_s    wr_stat, rd_stat;
    int          fail_count, checks;

    fq_queue dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .aclr(aclr), .sclr(sclr), .wr_in(wr_in), .wr_stat(wr_stat),
        .rd_req(rd_req), .rd_data(rd_data), .rd_stat(rd_stat));
    fq_far_end u_far (.push(push), .pop(pop), .rude(rude), .pdata(pdata),
        .wr_stat(wr_stat), .rd_stat(rd_stat), .wr_in(wr_in), .rd_req(rd_req));

    // ----------------------------------------
    // Clock, tasks
    // ----------------------------------------
    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            $display("wrong value %s expected %h seen %h", n, exp, seen);
            fail_count++;
        end
    endtask

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= `FQ_HSIZE_WORD;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rdv = hrdata;
    endtask

    task push_n(input int n, input logic [7:0] b);
        for (int i = 0; i <= n; i++)
        begin
            @(posedge hclk);
            push  <= (i < n);
            pdata <= b + 8'(i);
        end
    endtask

    task pop_chk(input int n, input logic [7:0] b);
        for (int i = 0; i <= n; i++)
        begin
            @(posedge hclk);
            pop <= (i < n);
            #1;
            if (i > 0) chk("rd_data", 32'(rd_data), 32'(b + 8'(i - 1)));
        end
    endtask

    task rude_op(input logic w);
        @(posedge hclk);
        rude <= 1'b1;
        push <= w;
        pop  <= ~w;
        @(posedge hclk);
        rude <= 1'b0;
        push <= 1'b0;
        pop  <= 1'b0;
        #1;
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        #200000;
        fail_count++;
        summarize();
    end

    initial
    begin
        {hresetn, hsel, hwrite, aclr, sclr, push, pop, rude} = 8'h0;
        {haddr, hwdata, rdv, htrans, hsize, pdata} = '0;
        fail_count = 0;
        checks = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        #1 chk("wr_stat", 32'(wr_stat), 32'h20);
        chk("rd_stat", 32'(rd_stat), 32'h20);
        ahb(1'b0, `FQ_OFF_CTRL, 32'h0);
        chk("ctrl", rdv, {28'h0, `FQ_CTRL_RST});
        ahb(1'b0, `FQ_OFF_STAT, 32'h0);
        chk("status", rdv, 32'h0a);
        ahb(1'b0, 8'h40, 32'h0);
        chk("unmapped", rdv, 32'h0);
        chk("hresp", 32'(hresp), 32'h0);
        chk("hreadyout", 32'(hreadyout), 32'h1);
        $display("test reset done");
        push_n(16, 8'h10);
        #1 chk("wr_stat", 32'(wr_stat), 32'h50);
        @(posedge hclk);
        #1 chk("rd_full", 32'(rd_stat.full), 32'h1);
        rude_op(1'b1);
        chk("level", 32'(wr_stat.level), 32'h10);
        ahb(1'b0, `FQ_OFF_STAT, 32'h0);
        chk("status", rdv, 32'h1015);
        ahb(1'b1, `FQ_OFF_STAT, 32'h30);
        pop_chk(16, 8'h10);
        rude_op(1'b0);
        chk("rd_stat", 32'(rd_stat), 32'h20);
        chk("rd_data", 32'(rd_data), 32'h1f);
        ahb(1'b0, `FQ_OFF_STAT, 32'h0);
        chk("status", rdv, 32'h2a);
        ahb(1'b1, `FQ_OFF_STAT, 32'h30);
        $display("test fill and guards done");
        ahb(1'b1, `FQ_OFF_CTRL, 32'h7);
        push_n(2, 8'ha5);
        #1 chk("head", 32'(rd_data), 32'ha5);
        pop_chk(1, 8'ha6);
        pop_chk(1, 8'ha6);
        push_n(3, 8'h30);
        ahb(1'b1, `FQ_OFF_CTRL, 32'h17);
        @(posedge hclk);
        #1 chk("rd_stat", 32'(rd_stat), 32'h20);
        push_n(3, 8'h40);
        @(posedge hclk);
        sclr <= 1'b1;
        push <= 1'b1;
        @(posedge hclk);
        sclr <= 1'b0;
        push <= 1'b0;
        #1 chk("rd_stat", 32'(rd_stat), 32'h20);
        $display("test show-ahead and clears done");
        ahb(1'b1, `FQ_OFF_CTRL, 32'h3);
        push_n(2, 8'h50);
        aclr <= 1'b1;
        #1 chk("wr_stat", 32'(wr_stat), 32'h20);
        chk("rd_data", 32'(rd_data), 32'h0);
        @(posedge hclk);
        aclr <= 1'b0;
        push_n(1, 8'h61);
        #1 chk("rd_stat", 32'(rd_stat), 32'h01);
        ahb(1'b1, `FQ_OFF_CTRL, 32'hb);
        ahb(1'b0, `FQ_OFF_CTRL, 32'h0);
        chk("ctrl", rdv, 32'hb);
        @(posedge hclk);
        aclr <= 1'b1;
        #1 chk("rd_stat", 32'(rd_stat), 32'h20);
        @(posedge hclk);
        aclr <= 1'b0;
        push_n(1, 8'h70);
        #1 chk("rd_stat", 32'(rd_stat), 32'h20);
        push_n(1, 8'h71);
        #1 chk("rd_stat", 32'(rd_stat), 32'h01);
        $display("test async clear done");
        summarize();
    end
endmodule
`default_nettype wire
